// ==== hdl/adcc_pkg.sv ====
package adcc_pkg;
   // ------------------------------------------------------------
   // widths and field positions
   // ------------------------------------------------------------
   localparam int RES_W = 16;
   localparam int LOW_W = 11;
   localparam int BIT_ELEVEN = 11;
   localparam int HIGH_LSB = 12;
   localparam int HIGH_W = 4;
   localparam int CNT_W = 12;
   localparam int BIT_CNT_W = 5;
   localparam logic [BIT_CNT_W-1:0] BITS_DONE = 5'h10;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 10;
   // conversion time, ns
   localparam int CONV_NS = 500;
   localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
   // calibration time after reset release, ns
   localparam int CAL_NS = 2000;
   localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
   // master bit clock: half period in ref cycles, edges per frame
   localparam int MCLK_HALF = 2;
   localparam int MCLK_EDGES = 40;

   // ------------------------------------------------------------
   // synchroniser lanes, ref domain
   // ------------------------------------------------------------
   localparam int S_CNV = 0;
   localparam int S_SEL = 1;
   localparam int S_RD = 2;
   localparam int S_RST = 3;
   localparam int S_SLP = 4;
   localparam int S_RSLP = 5;
   localparam int S_ASLP = 6;
   localparam int S_SER = 7;
   localparam int S_SLV = 8;
   localparam int S_RBSY = 9;
   localparam int RS_W = 10;
   localparam logic [RS_W-1:0] RS_INIT = 10'h007;
   // link domain lanes
   localparam int L_SEL = 0;
   localparam int L_TGL = 1;
   localparam int L_SLV = 2;
   localparam int LS_W = 3;
   localparam logic [LS_W-1:0] LS_INIT = 3'h1;

   typedef enum logic [1:0] {
      ADCC_IDLE = 2'b00,
      ADCC_CONV = 2'b01,
      ADCC_CAL = 2'b10
   } adcc_state_t;
endpackage

// ==== hdl/adcc_sync.sv ====
`timescale 1ns/1ps
module adcc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstN,
   // levels in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // two flops, the first read only by the second
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_reg <= INIT;
         q_reg <= INIT;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule // adcc_sync

// ==== hdl/adcc_top.sv ====
`timescale 1ns/1ps
// Operation
// - A falling convert strobe puts the sampler on hold and starts a conversion.
// - Busy rises at the start and falls once the result is latched for shifting.
// - Data output drivers are on only while select and read are both low; the bit clock driver follows the mode only.
// - In serial slave mode the bit clock counts only while select is low.
// - A serial slave read unfinished at conversion end is dropped and the flag pulses.
// - The shared pin gives result bit 11 in parallel mode and the flag in serial mode.
// - In parallel mode result bits 12 to 15 go on the upper data outputs.
// - While the reset input is high the device is held and a conversion aborts.
// - When the reset input falls a calibration runs, shown by a busy pulse.
// - With sleep high a running conversion ends and new starts are refused.
// - Reference sleep low enables the internal reference, high turns it off.
// - In serial mode the clock source select makes the bit clock pin an input or an output; in parallel mode it stays an input.
// - In slave mode data updates on the rising bit clock edge, swapped by invert.
module adcc_top
   import adcc_pkg::*;
#(
   parameter int CONV_CYCLES = adcc_pkg::CONV_CYC,
   parameter int CAL_CYCLES = adcc_pkg::CAL_CYC
) (
   // system clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // serial bit clock pin
   input wire logic bitClkIn,
   output logic bitClkOut,
   output logic bitClkOeN,
   // control pins
   input wire logic convertStrobeN,
   input wire logic selectN,
   input wire logic readN,
   input wire logic resetIn,
   input wire logic converterSleep,
   input wire logic referenceSleep,
   input wire logic refAmplifierSleep,
   input wire logic serialParallelSelect,
   input wire logic clockSourceSelect,
   input wire logic clockEdgeInvert,
   // digitised sample from the comparator array
   input wire logic [adcc_pkg::RES_W-1:0] sampleCode,
   // conversion status
   output logic busy,
   output logic sampleHold,
   // parallel result
   output logic [adcc_pkg::LOW_W-1:0] parallelLow,
   output logic resultBitEleven,
   output logic [adcc_pkg::HIGH_W-1:0] parallelHigh,
   output logic parallelOeN,
   // serial result
   output logic serialResultOut,
   output logic serialOeN,
   // power controls
   output logic refEnable,
   output logic refBufferEnable,
   output logic converterAwake
);
   import adcc_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [RS_W-1:0] rs;
   logic readBusy_reg;
   logic shiftClk;
   logic [LS_W-1:0] ls;
   logic wordTgl_reg;

   adcc_sync #(.W(RS_W), .INIT(RS_INIT)) u_ref_sync (
      .clk(ref_clk),
      .rstN(rst_n),
      .d({readBusy_reg, clockSourceSelect, serialParallelSelect, refAmplifierSleep,
          referenceSleep, converterSleep, resetIn, readN, selectN, convertStrobeN}),
      .q(rs)
   );

   logic serS;
   logic slvS;
   logic rstS;
   logic cnvDly_reg;
   logic rstDly_reg;
   logic cnvFall;
   logic rstFall;
   assign serS = rs[S_SER];
   assign slvS = rs[S_SLV];
   assign rstS = rs[S_RST];
   assign cnvFall = cnvDly_reg && !rs[S_CNV];
   assign rstFall = rstDly_reg && !rstS;

   // edge detect on synchronised levels
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnvDly_reg <= 1'b1;
         rstDly_reg <= 1'b0;
      end else begin
         cnvDly_reg <= rs[S_CNV];
         rstDly_reg <= rstS;
      end
   end

   // ------------------------------------------------------------
   // conversion sequencer
   // ------------------------------------------------------------
   adcc_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic busy_reg, busy_next;
   logic hold_reg, hold_next;
   logic [RES_W-1:0] code_reg, code_next;
   logic [RES_W-1:0] result_reg, result_next;
   logic wordTgl_next;
   logic errPulse;
   logic endConv;
   logic masterGo;

   assign endConv = (state_reg == ADCC_CONV) && (cnt_reg == '0) && !rstS && !rstFall;
   assign masterGo = endConv && serS && !slvS;

   // next state of the sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      busy_next = busy_reg;
      hold_next = hold_reg;
      code_next = code_reg;
      result_next = result_reg;
      wordTgl_next = wordTgl_reg;
      errPulse = 1'b0;
      if (rstS) begin
         state_next = ADCC_IDLE;
         cnt_next = '0;
         busy_next = 1'b0;
         hold_next = 1'b0;
      end else if (rstFall) begin
         state_next = ADCC_CAL;
         cnt_next = CNT_W'(CAL_CYCLES - 1);
         busy_next = 1'b1;
      end else begin
         unique case (state_reg)
            ADCC_IDLE: begin
               if (cnvFall && !rs[S_SLP]) begin
                  state_next = ADCC_CONV;
                  cnt_next = CNT_W'(CONV_CYCLES - 1);
                  busy_next = 1'b1;
                  hold_next = 1'b1;
                  code_next = sampleCode;
               end
            end
            ADCC_CONV: begin
               if (cnt_reg == '0) begin
                  state_next = ADCC_IDLE;
                  busy_next = 1'b0;
                  hold_next = 1'b0;
                  result_next = code_reg;
                  wordTgl_next = !wordTgl_reg;
                  errPulse = serS && slvS && rs[S_RBSY];
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end
            ADCC_CAL: begin
               if (cnt_reg == '0) begin
                  state_next = ADCC_IDLE;
                  busy_next = 1'b0;
               end else begin
                  cnt_next = cnt_reg - 1'b1;
               end
            end
            default: begin
               state_next = ADCC_IDLE;
               busy_next = 1'b0;
               hold_next = 1'b0;
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ADCC_IDLE;
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         hold_reg <= 1'b0;
         code_reg <= '0;
         result_reg <= '0;
         wordTgl_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         busy_reg <= busy_next;
         hold_reg <= hold_next;
         code_reg <= code_next;
         result_reg <= result_next;
         wordTgl_reg <= wordTgl_next;
      end
   end

   // ------------------------------------------------------------
   // master bit clock generator
   // ------------------------------------------------------------
   logic [CNT_W-1:0] mEdges_reg, mEdges_next;
   logic [CNT_W-1:0] mHalf_reg, mHalf_next;
   logic mClk_reg, mClk_next;

   // divide ref clock for a fixed burst after each conversion in serial master mode
   always_comb begin
      mEdges_next = mEdges_reg;
      mHalf_next = mHalf_reg;
      mClk_next = mClk_reg;
      if (rstS) begin
         mEdges_next = '0;
         mClk_next = 1'b0;
      end else if (masterGo) begin
         mEdges_next = CNT_W'(MCLK_EDGES);
         mHalf_next = CNT_W'(MCLK_HALF - 1);
      end else if (mEdges_reg != '0) begin
         if (mHalf_reg == '0) begin
            mClk_next = !mClk_reg;
            mEdges_next = mEdges_reg - 1'b1;
            mHalf_next = CNT_W'(MCLK_HALF - 1);
         end else begin
            mHalf_next = mHalf_reg - 1'b1;
         end
      end
   end

   // master clock registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mEdges_reg <= '0;
         mHalf_reg <= '0;
         mClk_reg <= 1'b0;
      end else begin
         mEdges_reg <= mEdges_next;
         mHalf_reg <= mHalf_next;
         mClk_reg <= mClk_next;
      end
   end

   // ------------------------------------------------------------
   // output pins and power controls
   // ------------------------------------------------------------
   logic [LOW_W-1:0] parLow_reg, parLow_next;
   logic bit11_reg, bit11_next;
   logic [HIGH_W-1:0] parHigh_reg, parHigh_next;
   logic parOeN_reg, parOeN_next;
   logic serOeN_reg, serOeN_next;
   logic clkOeN_reg, clkOeN_next;
   logic refEn_reg, refEn_next;
   logic bufEn_reg, bufEn_next;
   logic awake_reg, awake_next;
   logic readSel;

   assign readSel = !rs[S_SEL] && !rs[S_RD];

   // pin values
   always_comb begin
      parLow_next = result_next[LOW_W-1:0];
      bit11_next = serS ? errPulse : result_next[BIT_ELEVEN];
      parHigh_next = result_next[HIGH_LSB +: HIGH_W];
      // data drivers gated by select and read, bit clock driver by mode only
      parOeN_next = !(readSel && !serS);
      serOeN_next = !(readSel && serS);
      clkOeN_next = !(serS && !slvS);
      refEn_next = !rs[S_RSLP];
      bufEn_next = !rs[S_ASLP];
      awake_next = !rs[S_SLP] || (state_next != ADCC_IDLE);
   end

   // pin registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         parLow_reg <= '0;
         bit11_reg <= 1'b0;
         parHigh_reg <= '0;
         parOeN_reg <= 1'b1;
         serOeN_reg <= 1'b1;
         clkOeN_reg <= 1'b1;
         refEn_reg <= 1'b0;
         bufEn_reg <= 1'b0;
         awake_reg <= 1'b0;
      end else begin
         parLow_reg <= parLow_next;
         bit11_reg <= bit11_next;
         parHigh_reg <= parHigh_next;
         parOeN_reg <= parOeN_next;
         serOeN_reg <= serOeN_next;
         clkOeN_reg <= clkOeN_next;
         refEn_reg <= refEn_next;
         bufEn_reg <= bufEn_next;
         awake_reg <= awake_next;
      end
   end

   // ------------------------------------------------------------
   // link domain: serial shifter on the bit clock
   // ------------------------------------------------------------
   logic [RES_W-1:0] shift_reg, shift_next;
   logic [BIT_CNT_W-1:0] bitCnt_reg, bitCnt_next;
   logic sdo_reg, sdo_next;
   logic seen_reg, seen_next;
   logic readBusy_next;
   logic accept;

   assign shiftClk = bitClkIn ^ clockEdgeInvert;

   adcc_sync #(.W(LS_W), .INIT(LS_INIT)) u_link_sync (
      .clk(shiftClk),
      .rstN(rst_n),
      .d({clockSourceSelect, wordTgl_reg, selectN}),
      .q(ls)
   );

   assign accept = !ls[L_SLV] || !ls[L_SEL];

   // load a new word or shift one bit out, msb first
   always_comb begin
      shift_next = shift_reg;
      bitCnt_next = bitCnt_reg;
      sdo_next = sdo_reg;
      seen_next = seen_reg;
      if (ls[L_TGL] != seen_reg) begin
         // drop any partial read, word is stable behind the toggle
         shift_next = result_reg;
         bitCnt_next = '0;
         seen_next = ls[L_TGL];
      end else if (accept && (bitCnt_reg != BITS_DONE)) begin
         sdo_next = shift_reg[RES_W-1];
         shift_next = {shift_reg[RES_W-2:0], 1'b0};
         bitCnt_next = bitCnt_reg + 1'b1;
      end
      readBusy_next = (bitCnt_next != '0) && (bitCnt_next != BITS_DONE);
   end

   // link registers
   always_ff @(posedge shiftClk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg <= '0;
         bitCnt_reg <= BITS_DONE;
         sdo_reg <= 1'b0;
         seen_reg <= 1'b0;
         readBusy_reg <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         bitCnt_reg <= bitCnt_next;
         sdo_reg <= sdo_next;
         seen_reg <= seen_next;
         readBusy_reg <= readBusy_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign busy = busy_reg;
   assign sampleHold = hold_reg;
   assign parallelLow = parLow_reg;
   assign resultBitEleven = bit11_reg;
   assign parallelHigh = parHigh_reg;
   assign parallelOeN = parOeN_reg;
   assign serialResultOut = sdo_reg;
   assign serialOeN = serOeN_reg;
   assign bitClkOut = mClk_reg;
   assign bitClkOeN = clkOeN_reg;
   assign refEnable = refEn_reg;
   assign refBufferEnable = bufEn_reg;
   assign converterAwake = awake_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_start_hold: assert property (
      (state_reg == ADCC_IDLE && cnvFall && !rs[S_SLP] && !rstS && !rstFall)
      |=> busy && sampleHold && state_reg == ADCC_CONV)
      else $error("conversion did not start on strobe");
   a_busy_end: assert property (
      endConv |=> !busy && result_reg == $past(code_reg) && wordTgl_reg != $past(wordTgl_reg))
      else $error("busy fell without latched result");
   a_reset_abort: assert property (
      rstS |=> !busy && state_reg == ADCC_IDLE)
      else $error("reset did not abort");
   a_cal_pulse: assert property (
      (rstFall && !rstS) |=> busy && state_reg == ADCC_CAL)
      else $error("no calibration after reset");
   a_sleep_refuse: assert property (
      (state_reg == ADCC_IDLE && rs[S_SLP] && !rstFall) |=> state_reg != ADCC_CONV)
      else $error("start taken while asleep");
   a_read_error: assert property (
      (endConv && serS && slvS && rs[S_RBSY]) |=> resultBitEleven)
      else $error("incomplete read not flagged");
   a_drive_gate: assert property (
      !parallelOeN || !serialOeN |-> $past(readSel))
      else $error("drivers on without select and read");
   a_upper_bits: assert property (
      (endConv && !serS) |=> parallelHigh == $past(code_reg[HIGH_LSB +: HIGH_W]))
      else $error("upper data bits wrong");
   a_clk_dir: assert property (
      (serS && !slvS) [*2] |-> !bitClkOeN)
      else $error("master bit clock not driven");
   a_gate_clock: assert property (
      @(posedge shiftClk) disable iff (!rst_n)
      (ls[L_SLV] && ls[L_SEL] && ls[L_TGL] == seen_reg) |=> $stable(bitCnt_reg))
      else $error("bit clock counted without select");

   c_conversion: cover property (endConv);
   c_calibration: cover property (state_reg == ADCC_CAL ##1 state_reg == ADCC_IDLE);
   c_read_error: cover property (endConv && errPulse);
endmodule // adcc_top

// ==== dv/adcc_host_model.sv ====
`timescale 1ns/1ps
module adcc_host_model (
   // system clock
   input wire logic ref_clk,
   // device side of the bit clock pin and data
   input wire logic bitClkOut,
   input wire logic bitClkOeN,
   input wire logic serialResultOut,
   // control pins
   output logic convertStrobeN,
   output logic selectN,
   output logic readN,
   output logic bitClkIn
);
   logic hostClk;

   // ------------------------------------------------------------
   // pin resolution
   // ------------------------------------------------------------
   // device drives the pin only while its enable is low
   assign bitClkIn = bitClkOeN ? hostClk : bitClkOut;

   // idle levels, bit clock stands still outside frames
   initial begin
      convertStrobeN = 1'b1;
      selectN = 1'b1;
      readN = 1'b1;
      hostClk = 1'b0;
   end

   // ------------------------------------------------------------
   // host tasks
   // ------------------------------------------------------------
   // falling strobe edge
   // called just after a falling clock edge; pin returns high later
   task automatic start_conv();
      convertStrobeN = 1'b0;
      fork
         begin
            repeat (3) @(negedge ref_clk);
            convertStrobeN = 1'b1;
         end
      join_none
   endtask

   task automatic set_rd(input logic sel, input logic rd);
      @(negedge ref_clk);
      selectN = sel;
      readN = rd;
   endtask

   // bursts of host bit clock, offset from the system clock
   task automatic pulses(input int n);
      #7;
      repeat (n) begin
         #15 hostClk = 1'b1;
         #15 hostClk = 1'b0;
      end
   endtask

   // read after busy falls, sample on falling edge
   task automatic read_serial(input int nBits, output logic [15:0] word);
      word = 16'h0000;
      set_rd(1'b0, 1'b0);
      repeat (4) @(negedge ref_clk);
      pulses(3);
      repeat (nBits) begin
         #15 hostClk = 1'b1;
         #15 word = {word[14:0], serialResultOut};
         hostClk = 1'b0;
      end
      set_rd(1'b1, 1'b1);
   endtask
endmodule // adcc_host_model

// ==== dv/adcc_top_test.sv ====
`timescale 1ns/1ps
module adcc_top_test;
   import adcc_pkg::*;
   localparam int CONV = 8;
   localparam int CAL = 6;
   logic ref_clk, rst_n, resetIn, converterSleep, referenceSleep, refAmplifierSleep;
   logic serialParallelSelect, clockSourceSelect, clockEdgeInvert;
   logic [RES_W-1:0] sampleCode;
   logic convertStrobeN, selectN, readN, bitClkIn, bitClkOut, bitClkOeN;
   logic busy, sampleHold, resultBitEleven, parallelOeN, serialResultOut, serialOeN;
   logic refEnable, refBufferEnable, converterAwake;
   logic [LOW_W-1:0] parallelLow;
   logic [HIGH_W-1:0] parallelHigh;
   logic [15:0] word;
   logic [15:0] codes [3] = '{16'hA5C3, 16'h0800, 16'hF7FF};
   int n_errors = 0;
   int checks = 0;
   int nFlag = 0;
   int hi;
   int nRise = 0;
   logic [15:0] mWord;

   // ------------------------------------------------------------
   // instances
   // ------------------------------------------------------------
   adcc_top #(.CONV_CYCLES(CONV), .CAL_CYCLES(CAL)) i_adcc_top (
      .ref_clk(ref_clk), .rst_n(rst_n), .bitClkIn(bitClkIn), .bitClkOut(bitClkOut),
      .bitClkOeN(bitClkOeN), .convertStrobeN(convertStrobeN), .selectN(selectN),
      .readN(readN), .resetIn(resetIn), .converterSleep(converterSleep),
      .referenceSleep(referenceSleep), .refAmplifierSleep(refAmplifierSleep),
      .serialParallelSelect(serialParallelSelect), .clockSourceSelect(clockSourceSelect),
      .clockEdgeInvert(clockEdgeInvert), .sampleCode(sampleCode), .busy(busy),
      .sampleHold(sampleHold), .parallelLow(parallelLow), .resultBitEleven(resultBitEleven),
      .parallelHigh(parallelHigh), .parallelOeN(parallelOeN),
      .serialResultOut(serialResultOut), .serialOeN(serialOeN), .refEnable(refEnable),
      .refBufferEnable(refBufferEnable), .converterAwake(converterAwake));

   adcc_host_model i_adcc_host_model (
      .ref_clk(ref_clk), .bitClkOut(bitClkOut), .bitClkOeN(bitClkOeN),
      .serialResultOut(serialResultOut), .convertStrobeN(convertStrobeN),
      .selectN(selectN), .readN(readN), .bitClkIn(bitClkIn));

   // ------------------------------------------------------------
   // clock, flag monitor, watchdog
   // ------------------------------------------------------------
   // system clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // count incomplete-read pulses in serial mode, away from the launching edge
   always @(negedge ref_clk) begin
      if (serialParallelSelect === 1'b1 && resultBitEleven === 1'b1) nFlag++;
   end

   // count master bit clock periods
   always @(posedge bitClkOut) begin
      nRise++;
   end

   // take master bits 15 to 0 on the falls after periods 4 to 19
   always @(negedge bitClkOut) begin
      if (nRise >= 4 && nRise <= 19) mWord = {mWord[14:0], serialResultOut};
   end

   // cut a hang short
   initial begin
      #200000;
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      finish_test();
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   // compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // wait for busy, count its high cycles, optionally strobe again
   task automatic meas_busy(input bit again, input bit hold);
      int t;
      hi = 0;
      for (t = 0; t < 12 && busy !== 1'b1; t++) @(negedge ref_clk);
      while (busy === 1'b1 && hi < 1000) begin
         @(negedge ref_clk);
         hi++;
         if (hi == 1) check(16'(sampleHold), 16'(hold), "hold state");
         if (again && hi == 4) i_adcc_host_model.start_conv();
      end
   endtask

   // one conversion of a given code
   task automatic conv(input logic [15:0] code, input bit again);
      @(negedge ref_clk);
      sampleCode = code;
      i_adcc_host_model.start_conv();
      meas_busy(again, 1'b1);
   endtask

   // verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      resetIn = 1'b0;
      converterSleep = 1'b0;
      referenceSleep = 1'b0;
      refAmplifierSleep = 1'b0;
      serialParallelSelect = 1'b0;
      clockSourceSelect = 1'b1;
      clockEdgeInvert = 1'b0;
      sampleCode = 16'h0000;
      fork
         i_adcc_host_model.pulses(4);
         repeat (20) @(negedge ref_clk);
      join
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      check(16'(busy), 16'h0000, "busy after reset");
      check(16'(parallelOeN), 16'h0001, "drivers after reset");
      $display("test reset done");
      // parallel conversions, second one with a refused strobe
      foreach (codes[i]) begin
         conv(codes[i], i == 1);
         check(16'(hi), 16'(CONV), "busy width");
         check({parallelHigh, resultBitEleven, parallelLow}, codes[i], "word");
         if (i == 1) begin
            repeat (8) @(negedge ref_clk);
            check(16'(busy), 16'h0000, "strobe in conversion");
         end
      end
      $display("test parallel done");
      // output enable needs both select and read
      i_adcc_host_model.set_rd(1'b0, 1'b1);
      repeat (5) @(negedge ref_clk);
      check(16'(parallelOeN), 16'h0001, "select only");
      i_adcc_host_model.set_rd(1'b0, 1'b0);
      repeat (2) @(negedge ref_clk);
      check(16'(parallelOeN), 16'h0001, "enable early");
      @(negedge ref_clk);
      check(16'(parallelOeN), 16'h0000, "both low");
      i_adcc_host_model.set_rd(1'b1, 1'b0);
      repeat (3) @(negedge ref_clk);
      check(16'(parallelOeN), 16'h0001, "read only");
      i_adcc_host_model.set_rd(1'b1, 1'b1);
      $display("test enable done");
      // abort by reset, refusal while held, then calibration
      @(negedge ref_clk);
      i_adcc_host_model.start_conv();
      repeat (6) @(negedge ref_clk);
      resetIn = 1'b1;
      repeat (3) @(negedge ref_clk);
      check(16'(busy), 16'h0000, "abort");
      i_adcc_host_model.start_conv();
      repeat (8) @(negedge ref_clk);
      check(16'(busy), 16'h0000, "strobe in reset");
      resetIn = 1'b0;
      meas_busy(1'b0, 1'b0);
      check(16'(hi), 16'(CAL), "calibration width");
      $display("test reset input done");
      // sleep lets the running conversion finish, then refuses
      @(negedge ref_clk);
      sampleCode = 16'h1234;
      i_adcc_host_model.start_conv();
      repeat (6) @(negedge ref_clk);
      converterSleep = 1'b1;
      meas_busy(1'b0, 1'b1);
      check({parallelHigh, resultBitEleven, parallelLow}, 16'h1234, "sleep word");
      i_adcc_host_model.start_conv();
      repeat (8) @(negedge ref_clk);
      check(16'(busy), 16'h0000, "strobe asleep");
      check(16'(converterAwake), 16'h0000, "asleep and idle");
      converterSleep = 1'b0;
      // reference on and off; buffer sleep switched along with it
      for (int k = 0; k < 2; k++) begin
         @(negedge ref_clk);
         referenceSleep = k[0];
         refAmplifierSleep = k[0];
         repeat (4) @(negedge ref_clk);
         check(16'(refEnable), 16'(!k[0]), "reference");
         check(16'(refBufferEnable), 16'(!k[0]), "buffer");
      end
      referenceSleep = 1'b0;
      refAmplifierSleep = 1'b0;
      $display("test power done");
      // serial slave: full read, partial read, replaced word
      @(negedge ref_clk);
      serialParallelSelect = 1'b1;
      repeat (4) @(negedge ref_clk);
      i_adcc_host_model.set_rd(1'b0, 1'b0);
      repeat (4) @(negedge ref_clk);
      check(16'(serialOeN), 16'h0000, "serial enable");
      check(16'(parallelOeN), 16'h0001, "parallel off in serial");
      i_adcc_host_model.set_rd(1'b1, 1'b1);
      repeat (4) @(negedge ref_clk);
      nFlag = 0;
      conv(16'hC35A, 1'b0);
      i_adcc_host_model.read_serial(16, word);
      check(word, 16'hC35A, "serial word");
      conv(16'h5AC3, 1'b0);
      repeat (4) @(negedge ref_clk);
      check(16'(nFlag), 16'h0000, "flag after full read");
      i_adcc_host_model.pulses(6);
      i_adcc_host_model.read_serial(5, word);
      check(word, 16'h0016, "gated clock");
      conv(16'h0FF0, 1'b0);
      repeat (4) @(negedge ref_clk);
      check(16'(nFlag), 16'h0001, "flag pulse");
      i_adcc_host_model.read_serial(16, word);
      check(word, 16'h0FF0, "replaced word");
      $display("test serial done");
      // clock source select turns the bit clock pin around
      clockSourceSelect = 1'b0;
      repeat (6) @(negedge ref_clk);
      check(16'(bitClkOeN), 16'h0000, "master drives");
      conv(16'h3C96, 1'b0);
      repeat (90) @(negedge ref_clk);
      check(16'(nRise), 16'h0014, "master periods");
      check(mWord, 16'h3C96, "master word");
      clockSourceSelect = 1'b1;
      repeat (6) @(negedge ref_clk);
      check(16'(bitClkOeN), 16'h0001, "slave releases");
      $display("test clock source done");
      finish_test();
   end
endmodule // adcc_top_test
